/* File: dv/tb_umspi_top.sv */
module tb_umspi_top
    import umspi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic         clock_i;
    logic         srst_i;
    umspi_cfg_t   cfg_i;
    logic         data_wr_i;
    logic [7:0]   data_wdata_i;
    logic         data_rd_i;
    logic [7:0]   data_rdata_o;
    logic         tx_complete_clr_i;
    umspi_flags_t flags_o;
    umspi_pin_t   port_serial_out_i;
    umspi_pin_t   port_transfer_clock_i;
    logic         port_serial_in_o;
    logic         rx_pin_owned_o;
    logic         serial_in_pin_i;
    umspi_pin_t   serial_out_pin_o;
    umspi_pin_t   transfer_clock_pin_o;
    logic         slv_en;
    logic [7:0]   slv_rx;
    logic [7:0]   slv_cnt;
    logic [7:0]   b;
    logic [7:0]   k;
    int           err_total;
    int           checked;

    umspi_top umspi_top_inst (
        .clock_i(clock_i), .srst_i(srst_i), .cfg_i(cfg_i), .data_wr_i(data_wr_i),
        .data_wdata_i(data_wdata_i), .data_rd_i(data_rd_i), .data_rdata_o(data_rdata_o),
        .tx_complete_clr_i(tx_complete_clr_i), .flags_o(flags_o),
        .port_serial_out_i(port_serial_out_i), .port_transfer_clock_i(port_transfer_clock_i),
        .port_serial_in_o(port_serial_in_o), .rx_pin_owned_o(rx_pin_owned_o),
        .serial_in_pin_i(serial_in_pin_i), .serial_out_pin_o(serial_out_pin_o),
        .transfer_clock_pin_o(transfer_clock_pin_o));

    umspi_slave umspi_slave_inst (
        .en_i(slv_en), .cfg_i(cfg_i), .sck_i(transfer_clock_pin_o.value),
        .mosi_i(serial_out_pin_o.value), .miso_o(serial_in_pin_i),
        .rx_o(slv_rx), .cnt_o(slv_cnt));

    // Clock; random port-side drive, port clock level held low for the slave
    always #2.5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        port_serial_out_i     <= 2'($urandom);
        port_transfer_clock_i <= {1'b0, 1'($urandom)};
    end

    ////////////////////////////////////////////////
    function automatic logic [7:0] reply(input logic [7:0] n);
        return 8'h5a ^ (n * 8'h1d);
    endfunction
    function automatic logic flag(input int sel);
        return sel == 0 ? flags_o.tx_buffer_empty_flag :
               sel == 1 ? flags_o.rx_complete_flag : flags_o.tx_complete_flag;
    endfunction
    task automatic test_done();
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_f(input int sel);
        int n;
        n = 0;
        @(negedge clock_i);
        while (flag(sel) !== 1'b1) begin
            if (++n > 2000) begin
                err_total++;
                test_done();
            end
            @(negedge clock_i);
        end
    endtask
    // Enables first with a zero divisor, the divisor one cycle later
    task automatic cfgset(input logic [1:0] md, input logic [4:0] bits, input logic [11:0] dv);
        @(posedge clock_i) slv_en <= 1'b0;
        cfg_i <= {md, bits, 12'h000};
        @(posedge clock_i) cfg_i.baud_divisor <= dv;
        repeat (3) @(posedge clock_i);
        slv_en <= 1'b1;
    endtask
    task automatic send(input logic [7:0] v);
        wait_f(0);
        @(posedge clock_i) data_wr_i <= 1'b1;
        data_wdata_i <= v;
        @(posedge clock_i) data_wr_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic read_chk(input logic [7:0] exp);
        wait_f(1);
        chk(data_rdata_o, exp);
        @(posedge clock_i) data_rd_i <= 1'b1;
        @(posedge clock_i) data_rd_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic clr_txc();
        @(posedge clock_i) tx_complete_clr_i <= 1'b1;
        @(posedge clock_i) tx_complete_clr_i <= 1'b0;
    endtask

    ////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hf1a2e7db));
        {clock_i, srst_i, slv_en, data_wr_i, data_rd_i, tx_complete_clr_i} = 6'h10;
        {data_wdata_i, port_serial_out_i, port_transfer_clock_i} = 12'h000;
        cfg_i = {2'b11, 5'b11000, 12'h000};
        repeat (3) @(posedge clock_i);
        srst_i <= 1'b0;
        // Every polarity, phase and order, one full-duplex byte each
        for (int m = 0; m < 8; m++) begin
            cfgset(2'b11, {2'b11, m[0], m[1], m[2]}, 12'(2 + $urandom % 4));
            b = m == 0 ? 8'h80 : m == 1 ? 8'h01 : 8'($urandom);
            k = slv_cnt;
            clr_txc();
            send(b);
            wait_f(2);
            read_chk(reply(k));
            chk(slv_rx, b);
        end
        // Three queued bytes, none read until the end
        cfgset(2'b11, 5'b11110, 12'h002);
        k = slv_cnt;
        clr_txc();
        for (int m = 0; m < 3; m++) send(8'h30 + 8'(m));
        wait_f(2);
        chk(slv_cnt, k + 8'h03);
        chk(slv_rx, 8'h32);
        read_chk(reply(k));
        read_chk(reply(k + 8'h01));
        chk(8'(flag(1)), 8'h00);
        clr_txc();
        @(negedge clock_i) chk(8'(flag(2)), 8'h00);
        // Transmit only
        cfgset(2'b11, 5'b10001, 12'h003);
        b = 8'($urandom);
        clr_txc();
        send(b);
        wait_f(2);
        chk(slv_rx, b);
        chk({7'h00, flag(1)}, 8'h00);
        chk({7'h00, rx_pin_owned_o}, 8'h00);
        // Other mode, then transmitter off: writes ignored, pins to port
        for (int m = 0; m < 2; m++) begin
            cfgset(m[0] ? 2'b11 : 2'b00, {!m[0], 4'b1000}, 12'h003);
            k = slv_cnt;
            send(8'($urandom));
            repeat (30) @(negedge clock_i);
            chk(slv_cnt, k);
            chk({7'h00, flag(0)}, 8'h01);
            chk(8'({serial_out_pin_o, transfer_clock_pin_o}),
                8'({port_serial_out_i, port_transfer_clock_i}));
            chk({7'h00, port_serial_in_o}, {7'h00, serial_in_pin_i});
        end
        test_done();
    end
endmodule // tb_umspi_top

/* File: dv/umspi_monitor.sv */
module umspi_monitor
    import umspi_pkg::*;
(
    // Clock and reset
    input wire logic         clock_i,
    input wire logic         srst_i,
    // Watched ports
    input wire umspi_cfg_t   cfg_i,
    input wire logic         data_wr_i,
    input wire umspi_flags_t flags_o,
    input wire umspi_pin_t   port_serial_out_i,
    input wire logic         rx_pin_owned_o,
    input wire umspi_pin_t   serial_out_pin_o,
    input wire umspi_pin_t   transfer_clock_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic        on;
    logic        ok;
    logic        tgl;
    logic        clk_reg;
    logic        steady_reg;
    umspi_cfg_t  cfg_reg;
    logic [3:0]  edge_reg;
    logic [11:0] gap_reg;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    // Transmitter owns the pins; steady config; clock pin toggle
    assign on  = cfg_i.mode_select_field == 2'b11 && cfg_i.transmitter_enable_bit;
    assign ok  = on && steady_reg && cfg_i == cfg_reg;
    assign tgl = ok && transfer_clock_pin_o.value != clk_reg;

    // Edges within a frame and cycles since the last edge
    always_ff @(posedge clock_i) begin
        clk_reg    <= transfer_clock_pin_o.value;
        cfg_reg    <= cfg_i;
        steady_reg <= cfg_i == cfg_reg;
        if (srst_i || !ok) begin
            edge_reg <= 4'h0;
            gap_reg  <= 12'h000;
        end else if (tgl) begin
            edge_reg <= edge_reg + 4'h1;
            gap_reg  <= 12'h000;
        end else if (gap_reg != 12'hfff) begin
            gap_reg <= gap_reg + 12'h001;
        end
    end

    ////////////////////////////////////////////////
    sequence s_on;
        on [*2];
    endsequence
    sequence s_off;
        (cfg_i.mode_select_field != 2'b11) [*2];
    endsequence
    sequence s_rx_on;
        (cfg_i.mode_select_field == 2'b11 && cfg_i.receiver_enable_bit) [*2];
    endsequence
    sequence s_rx_off;
        (!cfg_i.receiver_enable_bit) [*3];
    endsequence

    property p_flags_zero;
        {flags_o.framing_error_flag, flags_o.data_overrun_flag,
         flags_o.parity_error_flag} == 3'h0;
    endproperty
    property p_out_owned;
        s_on |-> serial_out_pin_o.oe;
    endproperty
    property p_clk_owned;
        s_on |-> transfer_clock_pin_o.oe;
    endproperty
    property p_out_port;
        s_off |-> serial_out_pin_o == port_serial_out_i;
    endproperty
    property p_rx_owned;
        s_rx_on |-> rx_pin_owned_o;
    endproperty
    property p_rx_off;
        s_rx_off |-> !rx_pin_owned_o && !flags_o.rx_complete_flag;
    endproperty
    property p_wr_tbe;
        data_wr_i && on |=> !flags_o.tx_buffer_empty_flag;
    endproperty
    property p_clk_fast;
        tgl && edge_reg != 4'h0 |-> gap_reg == cfg_i.baud_divisor;
    endproperty
    property p_clk_slow;
        ok && edge_reg != 4'h0 |-> gap_reg <= cfg_i.baud_divisor;
    endproperty
    property p_clk_idle;
        ok && edge_reg == 4'h0 && !tgl |->
            transfer_clock_pin_o.value == cfg_i.clock_polarity_bit;
    endproperty

    a_flags_zero: assert property (p_flags_zero) else $error("error flag set");
    a_out_owned: assert property (p_out_owned) else $error("data pin not owned");
    a_clk_owned: assert property (p_clk_owned) else $error("clock pin not owned");
    a_out_port: assert property (p_out_port) else $error("data pin not port");
    a_rx_owned: assert property (p_rx_owned) else $error("input pin not owned");
    a_rx_off: assert property (p_rx_off) else $error("receiver active");
    a_wr_tbe: assert property (p_wr_tbe) else $error("buffer empty after write");
    a_clk_fast: assert property (p_clk_fast) else $error("clock edge early");
    a_clk_slow: assert property (p_clk_slow) else $error("clock edge late");
    a_clk_idle: assert property (p_clk_idle) else $error("clock idle level");
endmodule // umspi_monitor

bind umspi_top umspi_monitor umspi_monitor_inst (
    .clock_i(clock_i), .srst_i(srst_i), .cfg_i(cfg_i), .data_wr_i(data_wr_i),
    .flags_o(flags_o), .port_serial_out_i(port_serial_out_i),
    .rx_pin_owned_o(rx_pin_owned_o), .serial_out_pin_o(serial_out_pin_o),
    .transfer_clock_pin_o(transfer_clock_pin_o)
);

/* File: dv/umspi_slave.sv */
module umspi_slave
    import umspi_pkg::*;
(
    // Control from the bench
    input  wire logic       en_i,
    input  wire umspi_cfg_t cfg_i,
    // SPI lines
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    output logic            miso_o,
    // Observed traffic
    output logic [7:0]      rx_o,
    output logic [7:0]      cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;

    int         n;
    int         idx;
    logic [7:0] sh;
    logic [7:0] tx;
    logic       mosi_dly;

    // Line as it stood just before a clock edge, as a slave's hold time sees it
    assign #1 mosi_dly = mosi_i;

    initial begin
        n     = 0;
        rx_o  = 8'h00;
        cnt_o = 8'h00;
    end

    // Reply byte per frame, bit chosen by edge count and order
    assign tx     = 8'h5a ^ (cnt_o * 8'h1d);
    assign idx    = (n == 0) ? 0 : (n - cfg_i.clock_phase_bit) / 2;
    assign miso_o = cfg_i.bit_order_bit ? tx[idx] : tx[7 - idx];

    // Even edges lead; sampling edge set by phase; 16 edges a frame
    always @(sck_i or negedge en_i) begin
        if (!en_i) begin
            n = 0;
        end else begin
            if (n[0] == cfg_i.clock_phase_bit) begin
                sh[cfg_i.bit_order_bit ? n / 2 : 7 - n / 2] = mosi_dly;
            end
            if (n == 15) begin
                rx_o  = sh;
                cnt_o = cnt_o + 8'h01;
                n     = 0;
            end else begin
                n = n + 1;
            end
        end
    end
endmodule // umspi_slave

/* File: rtl/umspi_baud.sv */
`include "umspi_defs.svh"

module umspi_baud
    import umspi_pkg::*;
#(
    parameter int DIV_W = 12
) (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             srst_i,
    // Control
    input  wire logic             run_i,
    input  wire logic [DIV_W-1:0] div_i,
    // Half-period tick
    output logic                  tick_o
);

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
    } umspi_baud_st_t;

    umspi_baud_st_t st_reg;
    umspi_baud_st_t st_next;

    // Tick every div+1 cycles, so the shift clock is clk / (2 * (div + 1))
    always_comb begin
        st_next = st_reg;
        tick_o  = 1'b0;
        if (!run_i) begin
            st_next.cnt = '0;
        end else if (st_reg.cnt >= div_i) begin
            st_next.cnt = '0;
            tick_o      = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + DIV_W'(1);
        end
    end

    // State register
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            st_reg.cnt <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule // umspi_baud

/* File: rtl/umspi_defs.svh */
`ifndef UMSPI_DEFS_SVH
`define UMSPI_DEFS_SVH

// Mode select code for master SPI operation
`define UMSPI_MODE_MASTER_SPI_EMULATION_MODE      2'b11
// Frame length in data bits
`define UMSPI_FRAME_BITS      8
// Index of the last clock edge of a frame (16 edges, 0..15)
`define UMSPI_LAST_EDGE       4'hf
// Reset values
`define UMSPI_RST_BYTE        8'h00
`define UMSPI_RST_IDLE_BYTE   8'hff
`define UMSPI_RST_EDGE        4'h0
`define UMSPI_RST_DIV         12'h000
// Receive buffer depth (completed bytes held beside the shift register)
`define UMSPI_RX_DEPTH        2

`endif

/* File: rtl/umspi_pkg.sv */
package umspi_pkg;

    // Transfer engine states
    typedef enum logic [0:0] {
        UMSPI_IDLE,
        UMSPI_SHIFT
    } umspi_state_t;

    // Static configuration from the control registers
    typedef struct packed {
        logic [1:0]  mode_select_field;
        logic        transmitter_enable_bit;
        logic        receiver_enable_bit;
        logic        clock_polarity_bit;
        logic        clock_phase_bit;
        logic        bit_order_bit;
        logic [11:0] baud_divisor;
    } umspi_cfg_t;

    // Status flags as software reads them
    typedef struct packed {
        logic tx_buffer_empty_flag;
        logic rx_complete_flag;
        logic tx_complete_flag;
        logic framing_error_flag;
        logic data_overrun_flag;
        logic parity_error_flag;
    } umspi_flags_t;

    // A pin as seen by a port: output value and output enable
    typedef struct packed {
        logic value;
        logic oe;
    } umspi_pin_t;

endpackage

/* File: rtl/umspi_rxbuf.sv */
`include "umspi_defs.svh"

module umspi_rxbuf
    import umspi_pkg::*;
#(
    parameter int DEPTH = `UMSPI_RX_DEPTH
) (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       srst_i,
    // Fill side
    input  wire logic       push_i,
    input  wire logic [7:0] push_data_i,
    // Drain side
    input  wire logic       pop_i,
    input  wire logic       flush_i,
    output logic [7:0]      head_o,
    output logic            not_empty_o
);

    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        logic [CW-1:0]         count;
    } umspi_rxbuf_st_t;

    umspi_rxbuf_st_t st_reg;
    umspi_rxbuf_st_t st_next;
    logic            do_pop;
    logic            do_push;

    assign head_o      = st_reg.mem[0];
    assign not_empty_o = (st_reg.count != '0);

    // Shift-out queue; a byte arriving at a full queue is dropped unless a read pops in the same cycle
    always_comb begin
        st_next = st_reg;
        do_pop  = pop_i && (st_reg.count != '0);
        do_push = push_i && ((st_reg.count != CW'(DEPTH)) || do_pop);
        if (do_pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                st_next.mem[i] = st_reg.mem[i+1];
            end
            st_next.count = st_reg.count - CW'(1);
        end
        if (do_push) begin
            st_next.mem[st_next.count] = push_data_i;
            st_next.count              = st_next.count + CW'(1);
        end
        if (flush_i) begin
            st_next.count = '0;
        end
    end

    // State register
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            st_reg.mem   <= '0;
            st_reg.count <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule // umspi_rxbuf

/* File: rtl/umspi_top.sv */
`include "umspi_defs.svh"

// Behaviour
// - Transfers start only while the transmitter is enabled; pending bytes still finish after it is disabled.
// - Enabled transmitter drives the serial output pin from its shift register.
// - Receiver is optional; transmit-only operation works.
// - Enabled receiver takes the serial input pin as shift input.
// - Transfer clock pin carries the shift clock in both cases.
// - A data write starts a transfer for sending and receiving.
// - Buffered byte enters the shift register only when it is free.
// - On overflow the newest received byte is dropped, older kept.
// - Receive-complete flag is set while received data is buffered.
// - Flags behave as in asynchronous operation.
// - Framing, overrun and parity flags always read zero.
// - Disabling transmitter or receiver behaves as in normal operation.
// - Polarity, phase and order bits act as on a standard SPI master.
// - Transmit path is double-buffered.
// - Receive path holds a completed byte while the next arrives.
// - No write-collision indication exists.
// - No double-speed control; faster clocks come from a smaller divisor.
// - Master only, no slave select.
// - Mode select field 11 selects master SPI mode.
// - Frames are eight bits, order chosen by one shared bit.
// - Data set up and sampled on opposite clock edges per mode.
// - Shift clock is system clock over two times divisor plus one.
module umspi_top
    import umspi_pkg::*;
#(
    parameter int DIV_W = 12
) (
    // Clock and reset
    input  wire logic         clock_i,
    input  wire logic         srst_i,
    // Configuration
    input  wire umspi_cfg_t   cfg_i,
    // Data register port
    input  wire logic         data_wr_i,
    input  wire logic [7:0]   data_wdata_i,
    input  wire logic         data_rd_i,
    output logic [7:0]        data_rdata_o,
    // Flags
    input  wire logic         tx_complete_clr_i,
    output umspi_flags_t      flags_o,
    // General port logic behind the pins
    input  wire umspi_pin_t   port_serial_out_i,
    input  wire umspi_pin_t   port_transfer_clock_i,
    output logic              port_serial_in_o,
    output logic              rx_pin_owned_o,
    // Pins
    input  wire logic         serial_in_pin_i,
    output umspi_pin_t        serial_out_pin_o,
    output umspi_pin_t        transfer_clock_pin_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Bit helpers

    // Bit on the line for the selected order
    function automatic logic umspi_out_bit(input logic [7:0] sh, input logic lsb_first);
        return lsb_first ? sh[0] : sh[`UMSPI_FRAME_BITS-1];
    endfunction

    // Shift one bit in, order as selected
    function automatic logic [7:0] umspi_shift(input logic [7:0] sh, input logic lsb_first,
                                               input logic b);
        return lsb_first ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction

    // First clock edge of a frame
    function automatic logic umspi_first_edge(input logic [3:0] idx);
        return idx == `UMSPI_RST_EDGE;
    endfunction

    // Last clock edge of a frame
    function automatic logic umspi_last_edge(input logic [3:0] idx);
        return idx == `UMSPI_LAST_EDGE;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        umspi_state_t state;
        logic [7:0]   tbuf;
        logic         tbuf_valid;
        logic [7:0]   tsh;
        logic [7:0]   rsh;
        logic [3:0]   edge_idx;
        logic         sclk;
        logic         txc;
        logic         sync1;
        logic         sync2;
    } umspi_st_t;

    umspi_st_t   st_reg;
    umspi_st_t   st_next;

    logic        mode_on;
    logic        tick;
    logic        frame_done;
    logic        sample_edge;
    logic        tx_owned;
    logic        rx_on;
    logic        rx_not_empty;
    logic [7:0]  rx_head;
    logic        load_now;
    logic        busy;
    logic        wr_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode and ownership

    // Master SPI mode only for field code 11
    assign mode_on  = (cfg_i.mode_select_field == `UMSPI_MODE_MASTER_SPI_EMULATION_MODE);
    // A frame is on the wire
    assign busy     = (st_reg.state == UMSPI_SHIFT);
    // Writes count only with the transmitter enabled; no collision flag
    assign wr_ok    = data_wr_i && mode_on && cfg_i.transmitter_enable_bit;
    // Transmitter stays owner until pending bytes are out
    assign tx_owned = mode_on && (cfg_i.transmitter_enable_bit
                                  || busy
                                  || st_reg.tbuf_valid);
    // Receiver active only when its enable is set
    assign rx_on    = mode_on && cfg_i.receiver_enable_bit;

    ////////////////////////////////////////////////////////////////////////////
    // Baud generator: half-period ticks from the divisor alone

    umspi_baud #(
        .DIV_W (DIV_W)
    ) u_baud (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .run_i   (busy),
        .div_i   (cfg_i.baud_divisor[DIV_W-1:0]),
        .tick_o  (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Receive buffer

    umspi_rxbuf #(
        .DEPTH (`UMSPI_RX_DEPTH)
    ) u_rxbuf (
        .clock_i     (clock_i),
        .srst_i      (srst_i),
        .push_i      (frame_done && rx_on),
        .push_data_i (st_next.rsh),
        .pop_i       (data_rd_i),
        .flush_i     (!rx_on),
        .head_o      (rx_head),
        .not_empty_o (rx_not_empty)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Transfer engine

    // Even edges lead, odd edges trail; sampling edge set by phase
    assign sample_edge = (st_reg.edge_idx[0] == cfg_i.clock_phase_bit);
    assign frame_done  = busy && tick && umspi_last_edge(st_reg.edge_idx);

    // Next state of the transfer engine
    always_comb begin
        st_next  = st_reg;
        load_now = 1'b0;

        // Input synchroniser for the serial input pin
        st_next.sync1 = serial_in_pin_i;
        st_next.sync2 = st_reg.sync1;

        // Idle waits for a byte; shift walks sixteen clock edges
        case (st_reg.state)
            UMSPI_IDLE: begin
                st_next.sclk = cfg_i.clock_polarity_bit;
                load_now     = st_reg.tbuf_valid;
            end
            UMSPI_SHIFT: begin
                if (tick) begin
                    st_next.sclk     = ~st_reg.sclk;
                    st_next.edge_idx = st_reg.edge_idx + 4'h1;
                    if (sample_edge) begin
                        st_next.rsh = umspi_shift(st_reg.rsh, cfg_i.bit_order_bit,
                                                  st_reg.sync2);
                    end else if (!umspi_first_edge(st_reg.edge_idx)
                                 && !umspi_last_edge(st_reg.edge_idx)) begin
                        // Setup edge moves the next bit out
                        st_next.tsh = umspi_shift(st_reg.tsh, cfg_i.bit_order_bit,
                                                  1'b1);
                    end else if (umspi_first_edge(st_reg.edge_idx)
                                 && !cfg_i.clock_phase_bit) begin
                        st_next.tsh = umspi_shift(st_reg.tsh, cfg_i.bit_order_bit,
                                                  1'b1);
                    end
                    if (umspi_last_edge(st_reg.edge_idx)) begin
                        // Back to back when another byte waits
                        st_next.state = UMSPI_IDLE;
                        st_next.tsh   = `UMSPI_RST_IDLE_BYTE;
                        load_now      = st_reg.tbuf_valid;
                        if (!st_reg.tbuf_valid) begin
                            st_next.txc = 1'b1;
                        end
                    end
                end
            end
            default: begin
                st_next.state = UMSPI_IDLE;
            end
        endcase

        // Move buffered byte into the free shift register
        if (load_now) begin
            st_next.state      = UMSPI_SHIFT;
            st_next.tsh        = st_reg.tbuf;
            st_next.tbuf_valid = 1'b0;
            st_next.edge_idx   = `UMSPI_RST_EDGE;
            st_next.sclk       = cfg_i.clock_polarity_bit;
        end

        // Transmit complete clears on request; a new set wins
        if (tx_complete_clr_i && !frame_done) begin
            st_next.txc = 1'b0;
        end

        // Data write fills the buffer and starts the exchange; no collision
        if (wr_ok) begin
            st_next.tbuf       = data_wdata_i;
            st_next.tbuf_valid = 1'b1;
        end

        // Leaving the mode drops the engine at once
        if (!mode_on) begin
            st_next.state      = UMSPI_IDLE;
            st_next.tbuf_valid = 1'b0;
            st_next.tsh        = `UMSPI_RST_IDLE_BYTE;
            st_next.sclk       = cfg_i.clock_polarity_bit;
        end
    end

    // State register
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            st_reg.state      <= UMSPI_IDLE;
            st_reg.tbuf       <= `UMSPI_RST_BYTE;
            st_reg.tbuf_valid <= 1'b0;
            st_reg.tsh        <= `UMSPI_RST_IDLE_BYTE;
            st_reg.rsh        <= `UMSPI_RST_BYTE;
            st_reg.edge_idx   <= `UMSPI_RST_EDGE;
            // Clock rests at its polarity level straight out of reset
            st_reg.sclk       <= cfg_i.clock_polarity_bit;
            st_reg.txc        <= 1'b0;
            st_reg.sync1      <= 1'b0;
            st_reg.sync2      <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pins; no slave select exists here, master only

    // Serial output from the shift register while transmitter owns it, else from the port
    always_comb begin
        if (tx_owned) begin
            serial_out_pin_o.value = umspi_out_bit(st_reg.tsh, cfg_i.bit_order_bit);
            serial_out_pin_o.oe    = 1'b1;
        end else begin
            serial_out_pin_o = port_serial_out_i;
        end
    end

    // Transfer clock likewise; rests at the polarity level between frames
    always_comb begin
        if (tx_owned) begin
            transfer_clock_pin_o.value = st_reg.sclk;
            transfer_clock_pin_o.oe    = 1'b1;
        end else begin
            transfer_clock_pin_o = port_transfer_clock_i;
        end
    end

    // Synchronised input level, always visible to the port
    assign port_serial_in_o = st_reg.sync2;
    // Receiver takes the input pin while it runs
    assign rx_pin_owned_o   = rx_on;

    ////////////////////////////////////////////////////////////////////////////
    // Data and flags

    // Buffer head; stale value once the buffer runs empty
    assign data_rdata_o = rx_head;
    // Flags as software polls them
    always_comb begin
        flags_o.tx_buffer_empty_flag = !st_reg.tbuf_valid;
        flags_o.rx_complete_flag     = rx_not_empty;
        flags_o.tx_complete_flag     = st_reg.txc;
        flags_o.framing_error_flag   = 1'b0;
        flags_o.data_overrun_flag    = 1'b0;
        flags_o.parity_error_flag    = 1'b0;
    end

endmodule // umspi_top
